//--- design/pscf_pkg.sv
// shared constants for the status, control and suspend-flag register group
package pscf_pkg;
   localparam int unsigned PSCF_AW = 8;
   localparam int unsigned PSCF_DW = 8;
   localparam logic [7:0] PSCF_OFS_STATUS = 8'h05;
   localparam logic [7:0] PSCF_OFS_CONTROL = 8'h06;
   localparam logic [7:0] PSCF_OFS_FLAGS = 8'h07;
   localparam logic [7:0] PSCF_CONTROL_RST = 8'h00;
   localparam logic [7:0] PSCF_FLAGS_RST = 8'h00;
   localparam logic [1:0] PSCF_STATUS_HI_RST = 2'b00;
   localparam int unsigned PSCF_BIT_SEAL = 7;
   localparam int unsigned PSCF_BIT_DEFMOD = 6;
   localparam int unsigned PSCF_BIT_LINE = 5;
   localparam int unsigned PSCF_BIT_BUTTON = 4;
   localparam int unsigned PSCF_BIT_MEASURE = 0;
   localparam int unsigned PSCF_BIT_PFSEL = 1;
   localparam logic [7:0] PSCF_CONTROL_MASK = 8'h03;
   // sequencer state codes shown in the status register
   typedef enum logic [1:0]
   {
      PSCF_SEQ_TRANS = 2'h0,
      PSCF_SEQ_AWAIT = 2'h1,
      PSCF_SEQ_ACTIVE = 2'h2,
      PSCF_SEQ_SUSPEND = 2'h3
   } pscf_seq_t;
endpackage

//--- design/pscf_flag_capture.sv
// captures which rails stayed enabled while in suspend
`timescale 1ns/1ns
module pscf_flag_capture
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wake_from_suspend,
   input wire logic i_wake_from_off,
   input wire logic [7:0] i_rail_en_in_suspend,
   output logic [7:0] o_flags
);
   import pscf_pkg::*;
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_flags <= PSCF_FLAGS_RST;
      else if (i_wake_from_off)
         o_flags <= PSCF_FLAGS_RST; // [RQ12]
      else if (i_wake_from_suspend)
         o_flags <= i_rail_en_in_suspend; // [RQ11] [RQ12]
   end
endmodule

//--- design/pscf_regs.sv
// status, control and suspend-flag register group with its port access
`timescale 1ns/1ns
// Overview of operation
// [RQ1] status bit 7 reads 1 once the factory seal is broken, else 0
// [RQ2] status bit 6 reads 1 when stored defaults differ from factory ones
// [RQ3] status bit 5 is 1 while the line-power detect pin is low
// [RQ4] status bit 4 is 1 while the push-button pin is low
// [RQ5] status bits 3-2 give the sequencer state code
// [RQ6] status bits 1-0 give the backup cell charge level
// [RQ7] software triggers a cell measurement before trusting the level bits
// [RQ8] writing 1 to control bit 0 starts one measurement, bit self-clears
// [RQ9] control bit 1 set and power-fail low shuts all rails down to off
// [RQ10] control bit 1 clear leaves the sequencer alone on power-fail
// [RQ11] flag bits 7..0 mark rails enabled during suspend on wake from suspend
// [RQ12] flag bits read 0 after wake from off or for rails disabled
// [RQ13] flag register at 0x07, read-only, resets to 0x00
// [RQ14] control register at 0x06, resets to 0x00
// [RQ15] status register at 0x05, top two bits reset 0, rest live
// [RQ16] reserved control bits read zero and ignore writes
// [RQ17] status fields sampled continuously, reads have no side effects
module pscf_regs
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [pscf_pkg::PSCF_AW-1:0] i_addr,
   input wire logic [pscf_pkg::PSCF_DW-1:0] i_wdata,
   output logic [pscf_pkg::PSCF_DW-1:0] o_rdata,
   output logic o_rvalid,
   input wire logic i_factory_seal_broken,
   input wire logic i_defaults_modified,
   input wire logic i_line_power_detect_pin,
   input wire logic i_push_button_pin,
   input wire logic [1:0] i_seq_state,
   input wire logic [1:0] i_backup_cell_level,
   input wire logic i_powerfail_out_n,
   input wire logic i_wake_from_suspend,
   input wire logic i_wake_from_off,
   input wire logic [7:0] i_rail_en_in_suspend,
   output logic o_backup_cell_measure_go,
   output logic o_powerfail_shutdown_sel,
   output logic o_shutdown_all
);
   import pscf_pkg::*;

   logic [7:0] status_q;
   logic [7:0] flags;
   logic [7:0] rdata_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // live status, resampled every cycle, never touched by reads
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         status_q <= {PSCF_STATUS_HI_RST, 6'h00}; // [RQ15]
      end
      else
      begin
         status_q[PSCF_BIT_SEAL] <= i_factory_seal_broken; // [RQ1] [RQ17]
         status_q[PSCF_BIT_DEFMOD] <= i_defaults_modified; // [RQ2]
         status_q[PSCF_BIT_LINE] <= ~i_line_power_detect_pin; // [RQ3]
         status_q[PSCF_BIT_BUTTON] <= ~i_push_button_pin; // [RQ4]
         status_q[3:2] <= i_seq_state; // [RQ5]
         // only meaningful after a measurement has been run
         status_q[1:0] <= i_backup_cell_level; // [RQ6] [RQ7]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control: measurement start is a one-cycle pulse, so it self-clears
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_backup_cell_measure_go <= PSCF_CONTROL_RST[PSCF_BIT_MEASURE]; // [RQ14]
      else
         o_backup_cell_measure_go <= i_wr_en && hit(i_addr, PSCF_OFS_CONTROL)
            && i_wdata[PSCF_BIT_MEASURE]; // [RQ8]
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_powerfail_shutdown_sel <= PSCF_CONTROL_RST[PSCF_BIT_PFSEL]; // [RQ14]
      else if (i_wr_en && hit(i_addr, PSCF_OFS_CONTROL))
         o_powerfail_shutdown_sel <= i_wdata[PSCF_BIT_PFSEL];
   end

   // shutdown request only when selected; otherwise power-fail is ignored
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_shutdown_all <= 1'b0;
      else
         o_shutdown_all <= o_powerfail_shutdown_sel && !i_powerfail_out_n; // [RQ9] [RQ10]
   end

   ////////////////////////////////////////////////////////////////////////
   pscf_flag_capture u_flags
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wake_from_suspend(i_wake_from_suspend),
      .i_wake_from_off(i_wake_from_off),
      .i_rail_en_in_suspend(i_rail_en_in_suspend),
      .o_flags(flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // read mux; writes to status and flags are ignored
   always_comb
   begin
      rdata_d = 8'h00;
      if (hit(i_addr, PSCF_OFS_STATUS))
         rdata_d = status_q; // [RQ15] [RQ17]
      else if (hit(i_addr, PSCF_OFS_CONTROL))
         // measure bit reads 0 since it clears itself at once
         rdata_d = {6'h00, o_powerfail_shutdown_sel, 1'b0} & PSCF_CONTROL_MASK; // [RQ16]
      else if (hit(i_addr, PSCF_OFS_FLAGS))
         rdata_d = flags; // [RQ13]
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end
      else
      begin
         o_rvalid <= i_rd_en;
         if (i_rd_en)
            o_rdata <= rdata_d;
      end
   end
endmodule

//--- bench/pscf_regs_monitor.sv
// assertion checker for the register group ports
`timescale 1ns/1ns
module pscf_regs_monitor import pscf_pkg::*;
(
   input wire logic i_clk, i_rst, i_wr_en, i_rd_en, i_powerfail_out_n, o_rvalid,
   input wire logic i_factory_seal_broken, i_defaults_modified, i_line_power_detect_pin,
   input wire logic i_push_button_pin, o_backup_cell_measure_go, o_powerfail_shutdown_sel,
   input wire logic o_shutdown_all,
   input wire logic [7:0] i_addr, i_wdata, o_rdata,
   input wire logic [1:0] i_seq_state, i_backup_cell_level
);
   logic wc;
   logic [7:0] st;
   assign wc = i_wr_en && i_addr == PSCF_OFS_CONTROL;
   assign st = {i_factory_seal_broken, i_defaults_modified, !i_line_power_detect_pin,
      !i_push_button_pin, i_seq_state, i_backup_cell_level};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_measure_start: assert property (wc && i_wdata[0] |=> o_backup_cell_measure_go)
      else $error("no measure pulse");
   a_measure_quiet: assert property (!(wc && i_wdata[0]) |=> !o_backup_cell_measure_go)
      else $error("stray measure pulse");
   a_select_write: assert property (wc |=> o_powerfail_shutdown_sel == $past(i_wdata[1]))
      else $error("select not written");
   a_fail_shutdown: assert property (o_powerfail_shutdown_sel && !i_powerfail_out_n |=> o_shutdown_all)
      else $error("no shutdown");
   a_fail_ignored: assert property (!o_powerfail_shutdown_sel |=> !o_shutdown_all)
      else $error("shutdown without select");
   a_control_read: assert property (i_rd_en && i_addr == PSCF_OFS_CONTROL |=>
      o_rdata == {6'h00, $past(o_powerfail_shutdown_sel), 1'b0}) else $error("control read");
   a_unmapped_zero: assert property (i_rd_en && (i_addr < 5 || i_addr > 7) |=> !o_rdata)
      else $error("unmapped read not zero");
   a_status_live: assert property (i_rd_en && i_addr == 5 && !$past(i_rst) |=> o_rdata == $past(st, 2))
      else $error("status read");
   a_idle_quiet: assert property (!i_rd_en |=> !o_rvalid && $stable(o_rdata))
      else $error("read data moved");
   cover property (wc && i_wdata[0]);
   cover property (o_shutdown_all);
   cover property (i_rd_en && i_addr == PSCF_OFS_FLAGS);
endmodule
bind pscf_regs pscf_regs_monitor mon_u (.*);

//--- bench/pscf_regs_test.sv
// self-checking bench for the register group
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module pscf_regs_test;
   import pscf_pkg::*;
   logic i_clk = 0, i_rst = 1, wr = 0, rd = 0, seal = 0, defm = 0, line = 1, btn = 1;
   logic pfn = 1, ws = 0, wo = 0, rv, go, sel, shut;
   logic [7:0] addr = 0, wd = 0, rails = 0, rdata, e, me;
   logic [1:0] seq = 0, lvl = 0;
   logic [7:0] exp_q[$];
   int num_errors = 0, total_checks = 0, cyc = 0, seed = 86;
   pscf_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
      .i_wdata(wd), .o_rdata(rdata), .o_rvalid(rv), .i_factory_seal_broken(seal),
      .i_defaults_modified(defm), .i_line_power_detect_pin(line), .i_push_button_pin(btn),
      .i_seq_state(seq), .i_backup_cell_level(lvl), .i_powerfail_out_n(pfn),
      .i_wake_from_suspend(ws), .i_wake_from_off(wo), .i_rail_en_in_suspend(rails),
      .o_backup_cell_measure_go(go), .o_powerfail_shutdown_sel(sel), .o_shutdown_all(shut));
   initial forever #5 i_clk = ~i_clk;
   task test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task step();
      @(posedge i_clk);
      #1;
   endtask
   task rd_reg(input logic [7:0] a, input logic [7:0] x);
      rd = 1; addr = a; exp_q.push_back(x); step(); rd = 0;
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      wr = 1; addr = a; wd = d; step(); wr = 0;
   endtask
   // result watcher, runs off the edge so the registered answer has landed
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         num_errors++;
         test_done();
      end
      else
      begin
         #2 if (rv === 1'b1)
         begin
            me = exp_q.pop_front();
            `CHK("rdata", me, rdata)
         end
      end
   end
   initial
   begin
      repeat (16) @(posedge i_clk);
      #1 i_rst = 0;
      rd_reg(PSCF_OFS_CONTROL, 8'h00);
      rd_reg(PSCF_OFS_FLAGS, 8'h00);
      rd_reg(8'h08, 8'h00);
      repeat (8)
      begin
         {seal, defm, line, btn, seq, lvl} = 8'($random(seed));
         step();
         e = {seal, defm, ~line, ~btn, seq, lvl};
         rd_reg(PSCF_OFS_STATUS, e);
         rd_reg(PSCF_OFS_STATUS, e);
      end
      wr_reg(PSCF_OFS_CONTROL, 8'hff);
      `CHK("go", 1'b1, go)
      `CHK("sel", 1'b1, sel)
      rd_reg(PSCF_OFS_CONTROL, 8'h02);
      `CHK("go", 1'b0, go)
      pfn = 0;
      step();
      `CHK("shut", 1'b1, shut)
      wr_reg(PSCF_OFS_CONTROL, 8'h01);
      step();
      `CHK("shut", 1'b0, shut)
      `CHK("sel", 1'b0, sel)
      pfn = 1;
      rails = 8'($random(seed)); ws = 1; step(); ws = 0;
      rd_reg(PSCF_OFS_FLAGS, rails);
      wr_reg(PSCF_OFS_FLAGS, ~rails);
      rd_reg(PSCF_OFS_FLAGS, rails);
      wo = 1; ws = 1; step(); wo = 0; ws = 0;
      rd_reg(PSCF_OFS_FLAGS, 8'h00);
      repeat (3) step();
      test_done();
   end
endmodule
